// ---- core/lpc_mem_target.sv ----
// Device end: decodes LPC memory cycles and serves a byte array
//
// How it works
// R1 - Only start nibble 0000 begins a cycle
// R2 - Type bits 3:2 01 mean memory; bit0 ignored
// R3 - Type 010x decodes as memory read
// R4 - Type 011x decodes as memory write
// R5 - Eight address nibbles, most significant first
// R6 - Host drives 1111 once, then releases
// R7 - Device takes bus in second turnaround clock
// R8 - Read: SYNC 0000 in clock 13
// R9 - Read data low nibble then high
// R10 - Write data low then high into byte
// R11 - Write: SYNC 0000 in clock 15
// R12 - Clock 16 drive 1111, then release
// R13 - Clock 17 floats while host retakes bus
// R14 - Frame marks start; bus sampled each rising edge
// R15 - 4 Mbit: A31-A19 ones, A18-A0 index
// R16 - 2 Mbit: A31-A18 ones, A17-A0 index
// R17 - Unselected cycles leave bus released
// R18 - Bus released outside own drive clocks
`timescale 1ns/1ps
module lpc_mem_target
  import lpc_cycle_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Link
  lpc_link_if.dev          link,
  // Configuration: high selects 4 Mbit array
  input  wire logic        size_4m,
  // Write port toward the array owner
  output logic             wr_strobe,
  output logic [18:0]      wr_addr,
  output logic [7:0]       wr_data,
  // Read activity
  output logic             rd_strobe
);

  // ****************************************************************
  // Storage and cycle state
  // ****************************************************************
  logic [7:0]  mem [0:(1<<ADDR_W_4M)-1];
  phase_t      phase;
  logic [31:0] addr;
  logic [2:0]  nib_cnt;
  logic        is_write;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic [18:0] index;

  // Index cut to the configured size
  assign index = size_4m ? addr[18:0]                       // [R15]
                         : {1'b0, addr[17:0]};              // [R16]

  // ****************************************************************
  // Phase sequencer
  // ****************************************************************
  // A frame strobe aborts whatever is running, as on a real bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PH_IDLE;
    end else if (!link.frame_n) begin
      // Last frame clock carries the start nibble [R14]
      phase <= (link.lad == START_MEM) ? PH_TYPE : PH_SKIP; // [R1]
    end else begin
      unique case (phase)
        PH_IDLE:     phase <= PH_IDLE;
        PH_SKIP:     phase <= PH_SKIP;                      // [R17]
        PH_TYPE: begin
          if (link.lad[3:2] == CYCTYPE_MEM) begin           // [R2]
            phase <= PH_ADDR;
          end else begin
            phase <= PH_SKIP;                               // [R17]
          end
        end
        PH_ADDR: begin
          if (nib_cnt == ADDR_LAST) begin
            phase <= is_write ? PH_WDATA_LO : PH_TAR0;
          end
        end
        PH_WDATA_LO: phase <= PH_WDATA_HI;
        PH_WDATA_HI: phase <= PH_TAR0;
        PH_TAR0: begin
          // Host drives ones here and lets go [R6]
          phase <= addr_hit(addr, size_4m) ? PH_TAR1 : PH_SKIP; // [R17]
        end
        PH_TAR1:     phase <= PH_SYNC;                      // [R7]
        PH_SYNC:     phase <= is_write ? PH_BTAR0 : PH_RDATA_LO;
        PH_RDATA_LO: phase <= PH_RDATA_HI;
        PH_RDATA_HI: phase <= PH_BTAR0;
        PH_BTAR0:    phase <= PH_BTAR1;
        PH_BTAR1:    phase <= PH_IDLE;                      // [R13]
      endcase
    end
  end

  // ****************************************************************
  // Type, address and write data capture
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      is_write <= 1'b0;
      addr     <= ADDR_RESET;
      nib_cnt  <= 3'h0;
      wbyte    <= DATA_RESET;
    end else begin
      if (phase == PH_TYPE) begin
        is_write <= link.lad[1];                            // [R3] [R4]
        nib_cnt  <= 3'h0;
      end
      if (phase == PH_ADDR) begin
        addr    <= {addr[27:0], link.lad};                  // [R5]
        nib_cnt <= nib_cnt + 3'h1;
      end
      if (phase == PH_WDATA_LO) begin
        wbyte[3:0] <= link.lad;                             // [R10]
      end
      if (phase == PH_WDATA_HI) begin
        wbyte[7:4] <= link.lad;                             // [R10]
      end
    end
  end

  // ****************************************************************
  // Array access
  // ****************************************************************
  // Write commits at SYNC so a missed decode never touches the array
  always_ff @(posedge clk) begin
    if (phase == PH_SYNC && is_write) begin
      mem[index] <= wbyte;
    end
  end

  // Read byte fetched during the turnaround, ready by SYNC
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rbyte <= DATA_RESET;
    end else if (phase == PH_TAR1 && !is_write) begin
      rbyte <= mem[index];
    end
  end

  // Side strobes for the array owner
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      wr_addr   <= 19'h00000;
      wr_data   <= DATA_RESET;
    end else begin
      wr_strobe <= (phase == PH_SYNC) && is_write;
      rd_strobe <= (phase == PH_SYNC) && !is_write;
      if (phase == PH_SYNC && is_write) begin
        wr_addr <= index;
        wr_data <= wbyte;
      end
    end
  end

  // ****************************************************************
  // Bus drive
  // ****************************************************************
  // Drive starts in TAR1 so the device owns the bus at SYNC
  always_comb begin
    link.lad_dev_oe = 1'b0;                                 // [R18]
    link.lad_dev_o  = NIB_IDLE;
    unique case (phase)
      PH_TAR1: begin
        link.lad_dev_oe = 1'b1;                             // [R7]
        link.lad_dev_o  = NIB_IDLE;
      end
      PH_SYNC: begin
        link.lad_dev_oe = 1'b1;                             // [R8] [R11]
        link.lad_dev_o  = SYNC_READY;
      end
      PH_RDATA_LO: begin
        link.lad_dev_oe = 1'b1;
        link.lad_dev_o  = rbyte[3:0];                       // [R9]
      end
      PH_RDATA_HI: begin
        link.lad_dev_oe = 1'b1;
        link.lad_dev_o  = rbyte[7:4];                       // [R9]
      end
      PH_BTAR0: begin
        link.lad_dev_oe = 1'b1;                             // [R12]
        link.lad_dev_o  = NIB_IDLE;
      end
      default: begin
        link.lad_dev_oe = 1'b0;                             // [R17] [R18]
        link.lad_dev_o  = NIB_IDLE;
      end
    endcase
  end

endmodule : lpc_mem_target

// ---- pkg/lpc_cycle_pkg.sv ----
// Shared constants and types for the LPC memory cycle host and target
package lpc_cycle_pkg;

  // ****************************************************************
  // Field values
  // ****************************************************************
  localparam logic [3:0] START_MEM   = 4'h0;
  localparam logic [1:0] CYCTYPE_MEM = 2'h1;
  localparam logic [3:0] NIB_IDLE    = 4'hf;
  localparam logic [3:0] SYNC_READY  = 4'h0;
  localparam int         ADDR_NIBS   = 8;
  localparam logic [2:0] ADDR_LAST   = 3'h7;

  // ****************************************************************
  // Address decode for the two array sizes
  // ****************************************************************
  localparam int ADDR_W_4M = 19;
  localparam int ADDR_W_2M = 18;
  localparam logic [31:0] MASK_4M = 32'hfff80000;
  localparam logic [31:0] MASK_2M = 32'hfffc0000;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  localparam logic [7:0]  DATA_RESET = 8'h00;

  // Bus phases of one memory cycle, seen by either end
  typedef enum logic [3:0] {
    PH_IDLE, PH_TYPE, PH_ADDR, PH_WDATA_LO, PH_WDATA_HI, PH_TAR0,
    PH_TAR1, PH_SYNC, PH_RDATA_LO, PH_RDATA_HI, PH_BTAR0, PH_BTAR1,
    PH_SKIP
  } phase_t;

  // True when the address selects the array of the chosen size
  function automatic logic addr_hit(input logic [31:0] a,
                                    input logic        big);
    addr_hit = big ? ((a & MASK_4M) == MASK_4M)
                   : ((a & MASK_2M) == MASK_2M);
  endfunction : addr_hit

endpackage : lpc_cycle_pkg

// ---- pkg/lpc_link_if.sv ----
// Shared LPC link: frame strobe and 4-bit bus with two drivers
`timescale 1ns/1ps
interface lpc_link_if;
  logic       frame_n;     // Host frame strobe, active low
  logic [3:0] lad_host_o;  // Host drive value
  logic       lad_host_oe; // Host drives bus
  logic [3:0] lad_dev_o;   // Device drive value
  logic       lad_dev_oe;  // Device drives bus
  logic [3:0] lad;         // Resolved level, pulled up to ones

  // Pull-ups give ones when nobody drives
  assign lad = lad_dev_oe  ? lad_dev_o  :
               lad_host_oe ? lad_host_o : 4'hf;

  modport host (output frame_n, output lad_host_o, output lad_host_oe,
                input lad);
  modport dev  (input frame_n, output lad_dev_o, output lad_dev_oe,
                input lad);
endinterface : lpc_link_if

// ---- core/lpc_mem_host.sv ----
// Host end: issues single-byte LPC memory reads and writes
`timescale 1ns/1ps
module lpc_mem_host
  import lpc_cycle_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Link
  lpc_link_if.host         link,
  // Request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic [31:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  // Answer
  output logic             done,
  output logic             ack,
  output logic [7:0]       rdata
);

  // ****************************************************************
  // State
  // ****************************************************************
  phase_t      phase;
  logic [31:0] addr;
  logic [7:0]  wbyte;
  logic        is_write;
  logic [2:0]  nib_cnt;
  logic        synced;

  assign req_ready = (phase == PH_IDLE);

  // Sequencer; no wait-state SYNC support, any other nibble is an error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase    <= PH_IDLE;
      addr     <= ADDR_RESET;
      wbyte    <= DATA_RESET;
      is_write <= 1'b0;
      nib_cnt  <= 3'h0;
    end else begin
      unique case (phase)
        PH_IDLE: begin
          if (req_valid) begin
            phase    <= PH_SKIP;
            addr     <= req_addr;
            wbyte    <= req_wdata;
            is_write <= req_write;
          end
        end
        PH_SKIP:     phase <= PH_TYPE;   // Start clock, frame low
        PH_TYPE: begin
          phase   <= PH_ADDR;
          nib_cnt <= 3'h0;
        end
        PH_ADDR: begin
          addr    <= {addr[27:0], 4'h0};
          nib_cnt <= nib_cnt + 3'h1;
          if (nib_cnt == ADDR_LAST) begin
            phase <= is_write ? PH_WDATA_LO : PH_TAR0;
          end
        end
        PH_WDATA_LO: phase <= PH_WDATA_HI;
        PH_WDATA_HI: phase <= PH_TAR0;
        PH_TAR0:     phase <= PH_TAR1;
        PH_TAR1:     phase <= PH_SYNC;
        PH_SYNC:     phase <= is_write ? PH_BTAR0 : PH_RDATA_LO;
        PH_RDATA_LO: phase <= PH_RDATA_HI;
        PH_RDATA_HI: phase <= PH_BTAR0;
        PH_BTAR0:    phase <= PH_BTAR1;
        PH_BTAR1:    phase <= PH_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Answer capture
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      synced <= 1'b0;
      rdata  <= DATA_RESET;
      done   <= 1'b0;
      ack    <= 1'b0;
    end else begin
      done <= (phase == PH_BTAR1);
      if (phase == PH_TYPE) begin
        synced <= 1'b0;
      end
      if (phase == PH_SYNC) begin
        synced <= (link.lad == SYNC_READY);
      end
      if (phase == PH_RDATA_LO) begin
        rdata[3:0] <= link.lad;
      end
      if (phase == PH_RDATA_HI) begin
        rdata[7:4] <= link.lad;
      end
      if (phase == PH_BTAR1) begin
        ack <= synced;
      end
    end
  end

  // ****************************************************************
  // Bus drive
  // ****************************************************************
  // Host leaves the bus from TAR1 until it retakes it after the cycle
  always_comb begin
    link.frame_n     = (phase != PH_SKIP);
    link.lad_host_oe = 1'b0;
    link.lad_host_o  = NIB_IDLE;
    unique case (phase)
      PH_SKIP: begin
        link.lad_host_oe = 1'b1;
        link.lad_host_o  = START_MEM;                       // [R1] [R14]
      end
      PH_TYPE: begin
        link.lad_host_oe = 1'b1;
        link.lad_host_o  = {CYCTYPE_MEM, is_write, 1'b0}; // [R2] [R3] [R4]
      end
      PH_ADDR: begin
        link.lad_host_oe = 1'b1;
        link.lad_host_o  = addr[31:28];                     // [R5]
      end
      PH_WDATA_LO: begin
        link.lad_host_oe = 1'b1;
        link.lad_host_o  = wbyte[3:0];                      // [R10]
      end
      PH_WDATA_HI: begin
        link.lad_host_oe = 1'b1;
        link.lad_host_o  = wbyte[7:4];                      // [R10]
      end
      PH_TAR0: begin
        link.lad_host_oe = 1'b1;
        link.lad_host_o  = NIB_IDLE;                        // [R6]
      end
      default: begin
        link.lad_host_oe = 1'b0;                            // [R13]
        link.lad_host_o  = NIB_IDLE;
      end
    endcase
  end

endmodule : lpc_mem_host

// ---- tb/lpc_link_checker.sv ----
// Concurrent checks on the LPC link between host and memory target
`timescale 1ns/1ps
module lpc_link_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Link signals
  input wire logic       frame_n,
  input wire logic [3:0] lad_host_o,
  input wire logic       lad_host_oe,
  input wire logic [3:0] lad_dev_o,
  input wire logic       lad_dev_oe,
  input wire logic [3:0] lad
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [3:0] run;

  // Length of the current device drive run; saturates, five is the longest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) run <= 4'h0;
    else if (!lad_dev_oe) run <= 4'h0;
    else if (run != 4'hf) run <= run + 4'h1;
  end

  // ****
  // Cycle headers
  // ****
  sequence s_rd;
    !frame_n && lad == 4'h0 ##1 lad[3:1] == 3'b010;
  endsequence
  sequence s_wr;
    !frame_n && lad == 4'h0 ##1 lad[3:1] == 3'b011;
  endsequence

  a_no_contention: assert property (!(lad_dev_oe && lad_host_oe))
    else $error("both ends drive the link");
  a_host_start: assert property ($fell(frame_n) |-> lad == 4'h0)
    else $error("start nibble is not zero");
  a_type_memory: assert property ($rose(frame_n) |-> lad[3:2] == 2'b01)
    else $error("cycle type is not memory");
  a_header_silent: assert property (!frame_n |-> !lad_dev_oe [*8])
    else $error("device drives during header");
  a_host_tar: assert property (s_rd ##9 1'b1 |->
    lad_host_oe && lad == 4'hf ##1 !lad_host_oe)
    else $error("host turnaround wrong");
  a_read_answer: assert property (s_rd ##10 lad_dev_oe |-> lad == 4'hf
    ##1 lad_dev_oe && lad == 4'h0 ##1 lad_dev_oe [*2]
    ##1 lad_dev_oe && lad == 4'hf ##1 !lad_dev_oe)
    else $error("read answer sequence wrong");
  a_write_answer: assert property (s_wr ##12 lad_dev_oe |-> lad == 4'hf
    ##1 lad_dev_oe && lad == 4'h0 ##1 lad_dev_oe && lad == 4'hf
    ##1 !lad_dev_oe)
    else $error("write answer sequence wrong");
  a_drive_bound: assert property (lad_dev_oe |-> run < 4'h5)
    else $error("device drive run too long");
endmodule : lpc_link_checker

// ---- tb/lpc_memory_cycle_target_test.sv ----
// Self-checking bench: LPC host and memory target joined over the link
`timescale 1ns/1ps
module lpc_memory_cycle_target_test;
  // ****
  // Signals and instances
  // ****
  logic        clk, rst_n, size_4m, req_valid, req_write;
  logic        req_ready, done, ack, wr_strobe, rd_strobe;
  logic [31:0] req_addr;
  integer      seed;
  logic [7:0]  req_wdata, wr_data, rdata, got_d;
  logic [18:0] wr_addr, got_a;
  int          n_fail, checks_done, n_wr, n_rd, n_oe;
  // Second link cases: start, type, expected drive clocks
  logic [11:0] cases [6] = '{12'h045, 12'h055, 12'h073, 12'h540,
                             12'h080, 12'h040};

  lpc_link_if l ();
  lpc_link_if l2 ();
  lpc_mem_target i_lpc_mem_target (.clk(clk), .rst_n(rst_n), .link(l),
    .size_4m(size_4m), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_strobe(rd_strobe));
  lpc_mem_host i_lpc_mem_host (.clk(clk), .rst_n(rst_n), .link(l),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .done(done), .ack(ack),
    .rdata(rdata));
  // Second target faces a bench driver that can break the framing
  lpc_mem_target i_lpc_mem_target_b (.clk(clk), .rst_n(rst_n),
    .link(l2), .size_4m(1'b1), .wr_strobe(), .wr_addr(), .wr_data(),
    .rd_strobe());
  lpc_link_checker i_lpc_link_checker (.clk(clk), .rst_n(rst_n),
    .frame_n(l.frame_n), .lad_host_o(l.lad_host_o),
    .lad_host_oe(l.lad_host_oe), .lad_dev_o(l.lad_dev_o),
    .lad_dev_oe(l.lad_dev_oe), .lad(l.lad));

  // Free-running bus clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Capture committed writes and count strobes and second-link drives
  always @(posedge clk) begin
    if (wr_strobe) begin
      got_a = wr_addr;
      got_d = wr_data;
      n_wr++;
    end
    if (rd_strobe) n_rd++;
    if (l2.lad_dev_oe) n_oe++;
  end

  // ****
  // Tasks
  // ****
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Array index that the decode rules give for an address and a size
  function automatic logic [18:0] exp_idx(input logic [31:0] a,
                                          input logic        big);
    exp_idx = big ? a[18:0] : {1'b0, a[17:0]};
  endfunction : exp_idx

  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // One host request; bounded wait for done
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [7:0] d);
    int k;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
    chk("busy", req_ready, 1'b0);
    k = 0;
    while (!done && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk("latency", k, 17);
    chk("ready", req_ready, 1'b1);
    if (!done) results();
  endtask : xfer

  // Bench plays host on the second link; lad released after TAR0 of a read, after the low data nibble of a write
  task automatic drive2(input logic [3:0] st, ty, input logic [31:0] a);
    for (int i = 0; i <= 10; i++) begin
      @(negedge clk);
      l2.frame_n = (i != 0);
      l2.lad_host_oe = 1'b1;
      l2.lad_host_o = i == 0 ? st : i == 1 ? ty :
                      i < 10 ? a[4*(9-i)+:4] : 4'hf;
    end
    @(negedge clk);
    l2.lad_host_oe = 1'b0;
    repeat (8) @(negedge clk);
  endtask : drive2

  // Watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    results();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    logic [31:0] a;
    logic [7:0]  d;
    int          w0, r0, o0;
    seed = 32'h6641a591;
    n_fail = 0;
    checks_done = 0;
    {rst_n, size_4m, req_valid, req_write, req_addr, req_wdata} = '0;
    {l2.frame_n, l2.lad_host_oe, l2.lad_host_o} = 6'h20;
    repeat (20) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    // Random write, read-back and decode miss in both sizes
    for (int i = 0; i < 12; i++) begin
      size_4m = i[0];
      a = $random(seed);
      d = $random(seed);
      if (i < 2) a = 32'h0;
      if (i == 2 || i == 3) a = 32'hffffffff;
      a = a | (size_4m ? 32'hfff80000 : 32'hfffc0000);
      w0 = n_wr;
      xfer(1'b1, a, d);
      chk("wr ack", ack, 1'b1);
      chk("wr count", n_wr - w0, 1);
      chk("wr addr", got_a, exp_idx(a, size_4m));
      chk("wr data", got_d, d);
      a[size_4m ? 19 : 18] = 1'b0;
      xfer(1'b1, a, ~d);
      chk("miss ack", ack, 1'b0);
      chk("miss count", n_wr - w0, 1);
      a[size_4m ? 19 : 18] = 1'b1;
      r0 = n_rd;
      xfer(1'b0, a, 8'h00);
      chk("rd ack", ack, 1'b1);
      chk("rd data", rdata, d);
      chk("rd count", n_rd - r0, 1);
    end
    $display("Test link transfers done");
    // Bench-driven frames: good read, reserved bit, good write, bad start, foreign type, miss
    for (int j = 0; j < 6; j++) begin
      o0 = n_oe;
      drive2(cases[j][11:8], cases[j][7:4],
             j == 5 ? 32'h7fffffff : 32'hffffffff);
      chk("drive clocks", n_oe - o0, cases[j][3:0]);
    end
    $display("Test framing faults done");
    results();
  end
endmodule : lpc_memory_cycle_target_test
